/* design/pcs_top.sv */
// config status register bank for two bus functions, one flag bank per function
// assumes config requests and bus events are synchronous to clk_sys
// assumes command register enables arrive as inputs per function
//
// Behaviour
// - write one clears flag; reads side-effect free
// - parity error sets detected parity flag
// - enabled reported system error sets flag
// - master abort on own cycle sets flag
// - target abort on own cycle sets flag
// - own target abort termination sets flag
// - devsel timing field reads medium
// - master data parity needs three conditions
// - back-to-back capable bit reads zero
// - user feature bit reads zero
// - double speed bit reads zero
// - capability chain bit reads one
// - intx only when status set, enabled
// - interrupt disable leaves status tracking
// - reserved low bits read zero
// - sticky flags cleared only by global reset
// - each function has its own register
// - interrupt disable blocks intx drive
// - parity response disabled blocks perr and master data parity; detected parity still sets
// - address parity to serr needs both enables
`timescale 1ns/1ns
module pcs_top
    import pcs_pkg::*;
(
    input  wire logic                          clk_sys,
    input  wire logic                          rstn,
    input  wire logic                          soft_reset,
    input  wire pcs_cfg_req_t                  cfg_req,
    input  wire pcs_cmd_t [PCS_NUM_FUNCS-1:0]  cmd,
    input  wire pcs_evt_t [PCS_NUM_FUNCS-1:0]  evt,
    output logic          [15:0]               cfg_rdata,
    output logic                               cfg_ack,
    output logic          [PCS_NUM_FUNCS-1:0]  intx_assert,
    output logic                               perr_assert,
    output logic                               serr_assert
);

    // flag storage and qualified events
    logic [PCS_NUM_FUNCS-1:0][PCS_FLAG_CNT-1:0] flags;
    logic [PCS_NUM_FUNCS-1:0][PCS_FLAG_CNT-1:0] set_vec;
    logic [PCS_NUM_FUNCS-1:0][PCS_FLAG_CNT-1:0] clr_vec;
    logic [PCS_NUM_FUNCS-1:0]                   wr_hit;
    logic [PCS_NUM_FUNCS-1:0]                   serr_evt;
    logic [PCS_NUM_FUNCS-1:0]                   perr_evt;
    logic [PCS_NUM_FUNCS-1:0]                   intx_next;

    // output and status registers
    logic [PCS_NUM_FUNCS-1:0]                   int_status_reg;
    logic [PCS_NUM_FUNCS-1:0]                   intx_reg;
    logic [15:0]                                rdata_reg;
    logic [15:0]                                rdata_next;
    logic                                       ack_reg;
    logic                                       ack_next;
    logic                                       perr_reg;
    logic                                       perr_next;
    logic                                       serr_reg;
    logic                                       serr_next;

    // request decode
    wire logic                                  addr_hit;
    wire logic                                  rd_hit;
    wire logic                                  clr_lane;
    wire logic [PCS_FLAG_CNT-1:0]               clr_bits;
    wire logic [15:0]                           sel_word;
    wire logic                                  lesser_rst;

    assign addr_hit   = (cfg_req.addr == PCS_STATUS_OFFSET);
    assign rd_hit     = cfg_req.rd && addr_hit;
    assign clr_lane   = cfg_req.wr && addr_hit && cfg_req.be[1];
    assign lesser_rst = soft_reset;

    // write-one positions mapped onto the flag vector
    assign clr_bits = {
        cfg_req.wdata[PCS_BIT_DPE],
        cfg_req.wdata[PCS_BIT_SSE],
        cfg_req.wdata[PCS_BIT_RMA],
        cfg_req.wdata[PCS_BIT_RTA],
        cfg_req.wdata[PCS_BIT_STA],
        cfg_req.wdata[PCS_BIT_MDP]
    };

    // per function qualification and flag bank
    for (genvar f = 0; f < PCS_NUM_FUNCS; f++) begin : g_func

        assign wr_hit[f] = clr_lane && (cfg_req.func == PCS_FUNC_W'(f));

        assign clr_vec[f] = wr_hit[f] ? clr_bits : '0;

        assign serr_evt[f] = cmd[f].system_error_enable
                           && (evt[f].serr_report
                           || (evt[f].addr_parity_err
                           && cmd[f].parity_response_enable));

        assign perr_evt[f] = evt[f].data_parity_err
                           && cmd[f].parity_response_enable;

        assign set_vec[f][PCS_F_DPE] = evt[f].addr_parity_err
                                     | evt[f].data_parity_err;
        assign set_vec[f][PCS_F_SSE] = serr_evt[f];
        assign set_vec[f][PCS_F_RMA] = evt[f].master_abort;
        assign set_vec[f][PCS_F_RTA] = evt[f].target_abort_rcvd;
        assign set_vec[f][PCS_F_STA] = evt[f].target_abort_sig;
        assign set_vec[f][PCS_F_MDP] = evt[f].perr_seen
                                     && evt[f].bus_master
                                     && cmd[f].parity_response_enable;

        assign intx_next[f] = evt[f].int_pending
                            && !cmd[f].int_disable;

        pcs_flag_bank u_flags (
            .clk_sys (clk_sys),
            .rstn    (rstn),
            .set_vec (set_vec[f]),
            .clr_vec (clr_vec[f]),
            .flags   (flags[f])
        );

        a_dpe_set: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            (evt[f].addr_parity_err || evt[f].data_parity_err)
            |=> flags[f][PCS_F_DPE]
        ) else $error("detected parity flag not set");

        a_dpe_cause: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            $rose(flags[f][PCS_F_DPE])
            |-> $past(evt[f].addr_parity_err || evt[f].data_parity_err)
        ) else $error("detected parity flag set without cause");

        a_sse_gate: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            $rose(flags[f][PCS_F_SSE])
            |-> $past(cmd[f].system_error_enable)
        ) else $error("system error flag set while disabled");

        a_sse_set: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            (evt[f].serr_report && cmd[f].system_error_enable)
            |=> flags[f][PCS_F_SSE]
        ) else $error("system error flag not set");

        a_abort_flags: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            (evt[f].master_abort || evt[f].target_abort_rcvd
             || evt[f].target_abort_sig)
            |=> (flags[f][PCS_F_RMA] || !$past(evt[f].master_abort))
             && (flags[f][PCS_F_RTA] || !$past(evt[f].target_abort_rcvd))
             && (flags[f][PCS_F_STA] || !$past(evt[f].target_abort_sig))
        ) else $error("abort flag not set");

        a_abort_cause: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            $rose(flags[f][PCS_F_RMA]) |-> $past(evt[f].master_abort)
        ) else $error("master abort flag set without cause");

        a_mdp_cond: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            $rose(flags[f][PCS_F_MDP])
            |-> $past(evt[f].perr_seen && evt[f].bus_master
                      && cmd[f].parity_response_enable)
        ) else $error("master data parity flag set without cause");

        a_mdp_set: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            (evt[f].perr_seen && evt[f].bus_master
             && cmd[f].parity_response_enable)
            |=> flags[f][PCS_F_MDP]
        ) else $error("master data parity flag not set");

        a_w1c_clear: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            (wr_hit[f] && cfg_req.wdata[PCS_BIT_DPE]
             && !set_vec[f][PCS_F_DPE])
            |=> !flags[f][PCS_F_DPE]
        ) else $error("write one did not clear flag");

        a_zero_keep: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            (wr_hit[f] && !cfg_req.wdata[PCS_BIT_RMA]
             && flags[f][PCS_F_RMA])
            |=> flags[f][PCS_F_RMA]
        ) else $error("write zero changed flag");

        a_flag_fall: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            $past(rstn)
            |-> ($past(flags[f]) & ~flags[f] & ~$past(clr_vec[f])) == '0
        ) else $error("sticky flag dropped without write one");

        a_set_wins: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            (wr_hit[f] && cfg_req.wdata[PCS_BIT_STA]
             && evt[f].target_abort_sig)
            |=> flags[f][PCS_F_STA]
        ) else $error("clear won over set");

        a_intx_gate: assert property (
            @(posedge clk_sys) disable iff (!rstn || lesser_rst)
            intx_reg[f]
            |-> int_status_reg[f] && !$past(cmd[f].int_disable)
        ) else $error("intx driven while blocked");

        a_intx_drive: assert property (
            @(posedge clk_sys) disable iff (!rstn || lesser_rst)
            (evt[f].int_pending && !cmd[f].int_disable)
            |=> intx_reg[f]
        ) else $error("intx not driven while pending");

        a_int_track: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            ##1 !$past(lesser_rst)
            |-> int_status_reg[f] == $past(evt[f].int_pending)
        ) else $error("interrupt status stopped tracking");

        a_soft_keep: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            (lesser_rst && set_vec[f] == '0 && clr_vec[f] == '0)
            |=> flags[f] == $past(flags[f])
        ) else $error("lesser reset changed sticky flags");

        a_reset_word: assert property (
            @(posedge clk_sys) disable iff (!rstn)
            $past(!rstn)
            |-> pcs_status_word(flags[f], int_status_reg[f])
                == PCS_STATUS_RESET
        ) else $error("status word wrong after reset");

        a_perr_drive: assert property (
            @(posedge clk_sys) disable iff (!rstn || lesser_rst)
            (evt[f].data_parity_err && cmd[f].parity_response_enable)
            |=> perr_reg
        ) else $error("perr not requested for enabled parity error");

        a_serr_drive: assert property (
            @(posedge clk_sys) disable iff (!rstn || lesser_rst)
            (evt[f].addr_parity_err && cmd[f].system_error_enable
             && cmd[f].parity_response_enable)
            |=> serr_reg
        ) else $error("serr not requested for address parity error");

    end : g_func

    // selected function's word for a read
    assign sel_word = pcs_status_word(
        flags[cfg_req.func],
        int_status_reg[cfg_req.func]
    );

    assign rdata_next = rd_hit ? sel_word : PCS_READ_IDLE;
    assign ack_next   = cfg_req.rd || cfg_req.wr;

    // shared error pins: any function may request them
    assign perr_next = |perr_evt;
    assign serr_next = |serr_evt;

    // interrupt status tracks the condition, disable only gates intx
    always_ff @(posedge clk_sys) begin
        if (!rstn || lesser_rst) begin
            int_status_reg <= '0;
            intx_reg       <= '0;
        end else begin
            int_status_reg <= {
                evt[1].int_pending,
                evt[0].int_pending
            };
            intx_reg       <= intx_next;
        end
    end

    // config answer registers
    always_ff @(posedge clk_sys) begin
        if (!rstn || lesser_rst) begin
            rdata_reg <= PCS_READ_IDLE;
            ack_reg   <= 1'h0;
        end else begin
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
        end
    end

    // error pin requests
    always_ff @(posedge clk_sys) begin
        if (!rstn || lesser_rst) begin
            perr_reg <= 1'h0;
            serr_reg <= 1'h0;
        end else begin
            perr_reg <= perr_next;
            serr_reg <= serr_next;
        end
    end

    a_read_fixed: assert property (
        @(posedge clk_sys) disable iff (!rstn || lesser_rst)
        rd_hit
        |=> rdata_reg[PCS_BIT_DEVSEL_HI:PCS_BIT_DEVSEL_LO] == 2'h1
         && rdata_reg[PCS_BIT_FBB] == 1'h0
         && rdata_reg[PCS_BIT_UDF] == 1'h0
         && rdata_reg[PCS_BIT_DBL] == 1'h0
         && rdata_reg[PCS_BIT_CAPABILITY_CHAIN_PRESENT] == 1'h1
         && rdata_reg[2:0] == 3'h0
         && ack_reg
    ) else $error("hardwired status bits wrong");

    a_read_pure: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (cfg_req.rd && !cfg_req.wr && evt == '0 && !lesser_rst)
        |=> flags == $past(flags)
    ) else $error("read disturbed flags");

    a_read_flags: assert property (
        @(posedge clk_sys) disable iff (!rstn || lesser_rst)
        rd_hit
        |=> rdata_reg[PCS_BIT_DPE] == $past(flags[cfg_req.func][PCS_F_DPE])
         && rdata_reg[PCS_BIT_MDP] == $past(flags[cfg_req.func][PCS_F_MDP])
         && rdata_reg[PCS_BIT_INT] == $past(int_status_reg[cfg_req.func])
    ) else $error("read data does not show current flags");

    a_serr_gate: assert property (
        @(posedge clk_sys) disable iff (!rstn || lesser_rst)
        serr_reg
        |-> $past(serr_evt != '0)
    ) else $error("serr without enabled cause");

    a_perr_gate: assert property (
        @(posedge clk_sys) disable iff (!rstn || lesser_rst)
        perr_reg
        |-> $past(perr_evt != '0)
    ) else $error("perr while response disabled");

    assign cfg_rdata   = rdata_reg;
    assign cfg_ack     = ack_reg;
    assign intx_assert = intx_reg;
    assign perr_assert = perr_reg;
    assign serr_assert = serr_reg;

endmodule : pcs_top

/* design/pcs_pkg.sv */
// constants, carriers and the status word builder for the config status bank
// assumes one config access port shared by all functions
package pcs_pkg;

    localparam int          PCS_NUM_FUNCS      = 2;
    localparam int          PCS_FUNC_W         = 1;
    localparam int          PCS_FLAG_CNT       = 6;

    localparam logic [7:0]  PCS_STATUS_OFFSET  = 8'h06;
    localparam logic [15:0] PCS_STATUS_RESET   = 16'h0210;
    localparam logic [15:0] PCS_READ_IDLE      = 16'h0000;

    localparam int          PCS_BIT_DPE        = 15;
    localparam int          PCS_BIT_SSE        = 14;
    localparam int          PCS_BIT_RMA        = 13;
    localparam int          PCS_BIT_RTA        = 12;
    localparam int          PCS_BIT_STA        = 11;
    localparam int          PCS_BIT_DEVSEL_HI  = 10;
    localparam int          PCS_BIT_DEVSEL_LO  = 9;
    localparam int          PCS_BIT_MDP        = 8;
    localparam int          PCS_BIT_FBB        = 7;
    localparam int          PCS_BIT_UDF        = 6;
    localparam int          PCS_BIT_DBL        = 5;
    localparam int          PCS_BIT_CAPABILITY_CHAIN_PRESENT    = 4;
    localparam int          PCS_BIT_INT        = 3;

    localparam logic [1:0]  PCS_DEVSEL_MEDIUM  = 2'h1;
    localparam logic        PCS_BACK_TO_BACK   = 1'h0;
    localparam logic        PCS_USER_FEATURE   = 1'h0;
    localparam logic        PCS_DOUBLE_SPEED   = 1'h0;
    localparam logic        PCS_CAP_CHAIN      = 1'h1;

    // index of each sticky flag inside the flag vector
    localparam int          PCS_F_DPE          = 5;
    localparam int          PCS_F_SSE          = 4;
    localparam int          PCS_F_RMA          = 3;
    localparam int          PCS_F_RTA          = 2;
    localparam int          PCS_F_STA          = 1;
    localparam int          PCS_F_MDP          = 0;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [PCS_FUNC_W-1:0] func;
        logic [7:0]            addr;
        logic [1:0]            be;
        logic [15:0]           wdata;
    } pcs_cfg_req_t;

    typedef struct packed {
        logic int_disable;
        logic system_error_enable;
        logic parity_response_enable;
    } pcs_cmd_t;

    typedef struct packed {
        logic addr_parity_err;
        logic data_parity_err;
        logic serr_report;
        logic master_abort;
        logic target_abort_rcvd;
        logic target_abort_sig;
        logic perr_seen;
        logic bus_master;
        logic int_pending;
    } pcs_evt_t;

    // builds the visible status word from flags and interrupt status
    function automatic logic [15:0] pcs_status_word(
        input logic [PCS_FLAG_CNT-1:0] flags,
        input logic                    int_status
    );
        logic [15:0] w;
        w = 16'h0000;
        w[PCS_BIT_DPE] = flags[PCS_F_DPE];
        w[PCS_BIT_SSE] = flags[PCS_F_SSE];
        w[PCS_BIT_RMA] = flags[PCS_F_RMA];
        w[PCS_BIT_RTA] = flags[PCS_F_RTA];
        w[PCS_BIT_STA] = flags[PCS_F_STA];
        w[PCS_BIT_DEVSEL_HI:PCS_BIT_DEVSEL_LO] = PCS_DEVSEL_MEDIUM;
        w[PCS_BIT_MDP] = flags[PCS_F_MDP];
        w[PCS_BIT_FBB] = PCS_BACK_TO_BACK;
        w[PCS_BIT_UDF] = PCS_USER_FEATURE;
        w[PCS_BIT_DBL] = PCS_DOUBLE_SPEED;
        w[PCS_BIT_CAPABILITY_CHAIN_PRESENT] = PCS_CAP_CHAIN;
        w[PCS_BIT_INT] = int_status;
        return w;
    endfunction : pcs_status_word

endpackage : pcs_pkg

/* design/pcs_flag_bank.sv */
// sticky flag bank of one function, set by hardware, cleared by writing ones
// assumes set and clear vectors are single-cycle qualified strobes
`timescale 1ns/1ns
module pcs_flag_bank
    import pcs_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    rstn,
    input  wire logic [PCS_FLAG_CNT-1:0] set_vec,
    input  wire logic [PCS_FLAG_CNT-1:0] clr_vec,
    output logic      [PCS_FLAG_CNT-1:0] flags
);

    logic [PCS_FLAG_CNT-1:0] flags_reg;
    logic [PCS_FLAG_CNT-1:0] flags_next;

    // set wins over a clear in the same cycle
    assign flags_next = set_vec | (flags_reg & ~clr_vec);

    // only the global reset clears the flags
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;

endmodule : pcs_flag_bank

/* sim/pcs_bus_agent.sv */
// bus agent model: raises per-function bus events toward the status bank
// assumes its tasks are called on the falling edge of clk_sys
`timescale 1ns/1ns
module pcs_bus_agent
    import pcs_pkg::*;
(
    input  wire logic                     clk_sys,
    output pcs_evt_t [PCS_NUM_FUNCS-1:0]  evt
);
    initial evt = '0;

    // one-cycle event pulse, the interrupt level is kept as it was
    task automatic pulse(input int f, input pcs_evt_t e);
        pcs_evt_t idle;
        idle = '0;
        idle.int_pending = evt[f].int_pending;
        e.int_pending = idle.int_pending;
        @(negedge clk_sys);
        evt[f] = e;
        @(negedge clk_sys);
        evt[f] = idle;
    endtask : pulse

    task automatic set_int(input int f, input logic v);
        evt[f].int_pending = v;
    endtask : set_int
endmodule : pcs_bus_agent

/* sim/pcs_top_bench.sv */
// self-checking bench for the config status bank
// assumes the bus agent model drives the event inputs
`timescale 1ns/1ns
module pcs_top_bench import pcs_pkg::*;;
    logic                              clk_sys = 1'b0;
    logic                              rstn = 1'b0;
    logic                              soft_reset = 1'b0;
    pcs_cfg_req_t                      cfg_req = '0;
    pcs_cmd_t     [PCS_NUM_FUNCS-1:0]  cmd = '0;
    wire pcs_evt_t [PCS_NUM_FUNCS-1:0] evt;
    logic         [15:0]               cfg_rdata;
    logic                              cfg_ack;
    logic         [PCS_NUM_FUNCS-1:0]  intx_assert;
    logic                              perr_assert;
    logic                              serr_assert;
    int                                error_cnt = 0;
    int                                cmp_count = 0;
    int                                cyc = 0;
    logic         [8:0]                ev_tab [5] = '{9'h020, 9'h010, 9'h008, 9'h080, 9'h100};
    logic         [15:0]               fl_tab [5] = '{16'h2000, 16'h1000, 16'h0800,
                                                      16'h8000, 16'h8000};
    localparam logic [7:0]             OFF = PCS_STATUS_OFFSET;

    pcs_top dut (
        .clk_sys     (clk_sys),
        .rstn        (rstn),
        .soft_reset  (soft_reset),
        .cfg_req     (cfg_req),
        .cmd         (cmd),
        .evt         (evt),
        .cfg_rdata   (cfg_rdata),
        .cfg_ack     (cfg_ack),
        .intx_assert (intx_assert),
        .perr_assert (perr_assert),
        .serr_assert (serr_assert)
    );

    pcs_bus_agent agent (
        .clk_sys (clk_sys),
        .evt     (evt)
    );

    always #25 clk_sys = ~clk_sys;

    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            $display("timeout after %0d cycles", cyc);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one config access, ack looked at in the cycle after the request
    task automatic acc(input logic w, input int f, input logic [7:0] a,
                       input logic [1:0] be, input logic [15:0] d);
        @(negedge clk_sys);
        cfg_req.wr = w;
        cfg_req.rd = !w;
        cfg_req.func = f[PCS_FUNC_W-1:0];
        cfg_req.addr = a;
        cfg_req.be = be;
        cfg_req.wdata = d;
        @(negedge clk_sys);
        cfg_req = '0;
        chk(cfg_ack, 16'h0001);
    endtask : acc

    task automatic rd(input int f, input logic [7:0] a, input logic [15:0] exp);
        acc(1'b0, f, a, 2'h0, 16'h0000);
        chk(cfg_rdata, exp);
    endtask : rd

    task automatic wr(input int f, input logic [15:0] d, input logic [1:0] be);
        acc(1'b1, f, OFF, be, d);
    endtask : wr

    initial begin
        repeat (6) @(negedge clk_sys);
        rstn = 1'b1;
        rd(0, OFF, 16'h0210);
        rd(1, OFF, 16'h0210);
        rd(0, 8'h04, 16'h0000);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            agent.pulse(i % 2, pcs_evt_t'(ev_tab[i]));
            rd(i % 2, OFF, 16'h0210 | fl_tab[i]);
            rd(1 - i % 2, OFF, 16'h0210);
            wr(i % 2, ~fl_tab[i], 2'h3);
            rd(i % 2, OFF, 16'h0210 | fl_tab[i]);
            wr(i % 2, fl_tab[i], 2'h1);
            rd(i % 2, OFF, 16'h0210 | fl_tab[i]);
            wr(i % 2, fl_tab[i], 2'h3);
            rd(i % 2, OFF, 16'h0210);
        end
        $display("test flag set and clear done");
        agent.pulse(0, pcs_evt_t'(9'h040));
        chk(serr_assert, 16'h0000);
        rd(0, OFF, 16'h0210);
        cmd[0].system_error_enable = 1'b1;
        agent.pulse(0, pcs_evt_t'(9'h040));
        chk(serr_assert, 16'h0001);
        rd(0, OFF, 16'h4210);
        wr(0, 16'h4000, 2'h3);
        agent.pulse(0, pcs_evt_t'(9'h100));
        chk(serr_assert, 16'h0000);
        rd(0, OFF, 16'h8210);
        wr(0, 16'h8000, 2'h3);
        cmd[0].parity_response_enable = 1'b1;
        agent.pulse(0, pcs_evt_t'(9'h100));
        chk(serr_assert, 16'h0001);
        rd(0, OFF, 16'hC210);
        wr(0, 16'hC000, 2'h3);
        $display("test system error done");
        cmd[0] = '0;
        agent.pulse(0, pcs_evt_t'(9'h006));
        chk(perr_assert, 16'h0000);
        rd(0, OFF, 16'h0210);
        agent.pulse(0, pcs_evt_t'(9'h080));
        chk(perr_assert, 16'h0000);
        wr(0, 16'h8000, 2'h3);
        cmd[0].parity_response_enable = 1'b1;
        agent.pulse(0, pcs_evt_t'(9'h004));
        rd(0, OFF, 16'h0210);
        agent.pulse(0, pcs_evt_t'(9'h080));
        chk(perr_assert, 16'h0001);
        wr(0, 16'h8000, 2'h3);
        agent.pulse(0, pcs_evt_t'(9'h006));
        rd(0, OFF, 16'h0310);
        acc(1'b1, 0, 8'h04, 2'h3, 16'hFFFF);
        rd(0, OFF, 16'h0310);
        wr(0, 16'h0100, 2'h3);
        rd(0, OFF, 16'h0210);
        cmd[0] = '0;
        $display("test data parity done");
        fork
            agent.pulse(0, pcs_evt_t'(9'h028));
            wr(0, 16'h2800, 2'h3);
        join
        rd(0, OFF, 16'h2A10);
        @(negedge clk_sys);
        soft_reset = 1'b1;
        @(negedge clk_sys);
        soft_reset = 1'b0;
        rd(0, OFF, 16'h2A10);
        rstn = 1'b0;
        @(negedge clk_sys);
        rstn = 1'b1;
        rd(0, OFF, 16'h0210);
        $display("test resets done");
        agent.set_int(0, 1'b1);
        agent.set_int(1, 1'b1);
        @(negedge clk_sys);
        chk(intx_assert, 16'h0003);
        rd(0, OFF, 16'h0218);
        rd(1, OFF, 16'h0218);
        cmd[0].int_disable = 1'b1;
        @(negedge clk_sys);
        chk(intx_assert, 16'h0002);
        rd(0, OFF, 16'h0218);
        agent.set_int(0, 1'b0);
        agent.set_int(1, 1'b0);
        cmd[0].int_disable = 1'b0;
        @(negedge clk_sys);
        chk(intx_assert, 16'h0000);
        rd(0, OFF, 16'h0210);
        $display("test interrupt status done");
        tally_and_finish();
    end
endmodule : pcs_top_bench
